//--- logic/frac_n_pkg.sv
// Constants, register map and state type for the fractional-N divider timing core
package frac_n_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int HOLD_NS = 100;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] MOD_HI = 4'hb;
   localparam logic [3:0] MOD_LO = 4'ha;
   localparam logic [3:0] OSC_DIV = 4'ha;
   localparam logic [3:0] DOWN_PULSES = 4'hd;

   // Setting ranges
   localparam logic [9:0] N_MIN = 10'h1a4;
   localparam logic [9:0] N_MAX = 10'h2c0;
   localparam logic [13:0] FRAC_MAX = 14'h270f;
   localparam logic [16:0] PHASE_WRAP = 17'h186a0;
   localparam logic [16:0] FRAC_SCALE = 17'h0000a;

   // Register byte offsets
   localparam logic [3:0] OFS_INT_SET = 4'h0;
   localparam logic [3:0] OFS_FRAC_SET = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_COUNTERS = 4'hc;

   // Reset values
   localparam logic [9:0] INT_SET_RST = 10'h207;
   localparam logic [13:0] FRAC_SET_RST = 14'h0000;

   // Status field positions
   localparam int ST_PHASE_LSB = 0;
   localparam int ST_PEND_BIT = 17;
   localparam int ST_SWAL_BIT = 18;
   localparam int ST_UDONE_BIT = 19;
   localparam int ST_GATE_BIT = 20;
   localparam int ST_DOWN_BIT = 21;
   localparam int CT_TENS_LSB = 0;
   localparam int CT_UNITS_LSB = 8;

   // Responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [2:0] {SEQ_IDLE, SEQ_UP, SEQ_HOLD, SEQ_SAMPLE, SEQ_DOWN} seq_state_t;
endpackage : frac_n_pkg

//--- logic/fractional_n_divider_timing.sv
// Fractional-N divider timing core with AXI4-Lite settings port
// Functional notes
// - Divider pulse sets up-ramp gate; next 100 kHz reference pulse clears it.
// - 100 kHz reference is the 200 kHz input halved by one toggle flop.
// - Order per cycle: up-ramp, hold, sample strobe, then down ramp.
// - Down-ramp enable goes high for exactly 13 oscillator/10 pulses.
// - A high correction bit removes its sink; bits show phase during down ramp.
// - Zero fraction keeps every correction bit low.
// - One sample strobe closes both sample-and-hold stages together.
// - Counters take three integer digits; fraction logic takes four lower digits.
// - Integer value 420 to 704; fraction 0000 to 9999.
// - Units counter preloads low digit 0-9; tens counter upper digits 42-70.
// - Each division cycle with a nonzero units digit starts with the prescaler dividing by 11; a zero units digit starts at 10.
// - Each prescaler pulse decrements tens, and units while units still counts.
// - Units zero gives terminal pulse, stops units, prescaler goes divide by 10.
// - Tens zero ends the cycle, outputs a pulse, reloads both counters.
// - Integer sequence is independent of the fraction; swallow acts separately.
// - Fraction logic keeps phase in an accumulator and times swallows.
// - Each divider pulse adds fraction; overflow subtracts one, requests swallow.
// - Swallow makes the prescaler divide by 11 for one period, then 10.
// - Swallow arriving during divide by 11 or terminal count waits pending.
// - Phase shown as five decimal-weighted bits, first bit most significant.
`timescale 1ns/100ps
module fractional_n_divider_timing (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic osc_sample_in,
   input wire logic ref_200k_in,
   output logic divider_out,
   output logic up_ramp_gate,
   output logic sample_strobe,
   output logic down_ramp_en,
   output logic swallow_active,
   output logic units_terminal_pulse,
   output logic [4:0] phase_correction_bits
);
   logic [2:0] osc_sync_r;
   logic [2:0] ref_sync_r;
   logic osc_lvl_r, ref_lvl_r, osc_tick, ref_edge, ref_tick, ref_half_r;
   logic [9:0] int_set_r;
   logic [13:0] frac_set_r;
   logic [3:0] units_r, units_load;
   logic [6:0] tens_r, tens_load;
   logic [13:0] frac_act_r;
   logic [3:0] presc_cnt_r, modulus;
   logic units_done_r, swal_act_r, swal_pend_r, presc_out, cycle_end, swal_req, swal_apply;
   logic [16:0] phase_r;
   logic [17:0] phase_sum;
   logic [3:0] osc10_cnt_r;
   logic osc10_tick;
   frac_n_pkg::seq_state_t state_r;
   logic [3:0] seq_cnt_r;
   logic [4:0] corr_nxt;
   logic aw_held_r, w_held_r;
   logic [3:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic [31:0] rd_word;
   logic [1:0] rd_resp;

   // Pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_sync_r <= 3'h0;
         ref_sync_r <= 3'h0;
         osc_lvl_r <= 1'b0;
         ref_lvl_r <= 1'b0;
      end else begin
         osc_sync_r <= {osc_sync_r[1:0], osc_sample_in};
         ref_sync_r <= {ref_sync_r[1:0], ref_200k_in};
         if (osc_sync_r[1] == osc_sync_r[2]) osc_lvl_r <= osc_sync_r[2];
         if (ref_sync_r[1] == ref_sync_r[2]) ref_lvl_r <= ref_sync_r[2];
      end
   end
   assign osc_tick = (osc_sync_r[1] == osc_sync_r[2]) && osc_sync_r[2] && !osc_lvl_r;
   assign ref_edge = (ref_sync_r[1] == ref_sync_r[2]) && ref_sync_r[2] && !ref_lvl_r;
   assign ref_tick = ref_edge && !ref_half_r; // Rising edge of the halved reference
   // Single toggle flop halves the 200 kHz input
   always_ff @(posedge aclk) begin
      if (!aresetn) ref_half_r <= 1'b0;
      else if (ref_edge) ref_half_r <= !ref_half_r;
   end
   // Prescaler modulus: 11 until units terminal count, or for one swallow period
   assign modulus = (!units_done_r || swal_act_r) ? frac_n_pkg::MOD_HI : frac_n_pkg::MOD_LO;
   assign presc_out = osc_tick && (presc_cnt_r == modulus - 4'h1);
   assign cycle_end = presc_out && (tens_r == 7'h01);
   assign units_load = 4'(int_set_r % 10'd10);
   assign tens_load = 7'(int_set_r / 10'd10);

   always_ff @(posedge aclk) begin
      if (!aresetn) presc_cnt_r <= 4'h0;
      else if (presc_out) presc_cnt_r <= 4'h0;
      else if (osc_tick) presc_cnt_r <= presc_cnt_r + 4'h1;
   end
   // Integer counters; reset state makes the first prescaler pulse reload them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tens_r <= 7'h01;
         units_r <= 4'h0;
         units_done_r <= 1'b1;
         frac_act_r <= frac_n_pkg::FRAC_SET_RST;
         units_terminal_pulse <= 1'b0;
         divider_out <= 1'b0;
      end else begin
         units_terminal_pulse <= 1'b0;
         divider_out <= cycle_end;
         if (cycle_end) begin
            tens_r <= tens_load;
            units_r <= units_load;
            units_done_r <= (units_load == 4'h0);
            frac_act_r <= frac_set_r;
         end else if (presc_out) begin
            tens_r <= tens_r - 7'h01;
            if (!units_done_r) begin
               units_r <= units_r - 4'h1;
               if (units_r == 4'h1) begin
                  units_done_r <= 1'b1;
                  units_terminal_pulse <= 1'b1;
               end
            end
         end
      end
   end
   // Phase accumulator, stepped in units of 1/100000; the sum needs an 18th bit near full fraction
   assign phase_sum = 18'(phase_r) + 18'(frac_act_r) * 18'(frac_n_pkg::FRAC_SCALE);
   assign swal_req = cycle_end && (phase_sum >= 18'(frac_n_pkg::PHASE_WRAP));
   // A swallow may start only during divide by 10 and not alongside the terminal count
   assign swal_apply = presc_out && swal_pend_r && units_done_r && !swal_act_r && !units_terminal_pulse
                       && !cycle_end && (tens_r > 7'h02);

   always_ff @(posedge aclk) begin
      if (!aresetn) phase_r <= 17'h00000;
      else if (cycle_end) begin
         if (swal_req) phase_r <= 17'(phase_sum - 18'(frac_n_pkg::PHASE_WRAP));
         else phase_r <= 17'(phase_sum);
      end
   end
   // Pending flag: a new request wins over the clear that applies the old one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         swal_pend_r <= 1'b0;
         swal_act_r <= 1'b0;
      end else begin
         if (swal_req) swal_pend_r <= 1'b1;
         else if (swal_apply) swal_pend_r <= 1'b0;
         if (swal_apply) swal_act_r <= 1'b1;
         else if (presc_out) swal_act_r <= 1'b0;
      end
   end
   assign swallow_active = swal_act_r;
   // Oscillator divided by ten paces the down ramp
   always_ff @(posedge aclk) begin
      if (!aresetn) osc10_cnt_r <= 4'h0;
      else if (osc_tick) osc10_cnt_r <= (osc10_cnt_r == frac_n_pkg::OSC_DIV - 4'h1) ? 4'h0 : osc10_cnt_r + 4'h1;
   end
   assign osc10_tick = osc_tick && (osc10_cnt_r == frac_n_pkg::OSC_DIV - 4'h1);
   // Decimal-weighted correction digits; a bit is high when its digit is nonzero
   always_comb begin
      corr_nxt[4] = ((phase_r / 17'd10000) % 17'd10) != 17'd0;
      corr_nxt[3] = ((phase_r / 17'd1000) % 17'd10) != 17'd0;
      corr_nxt[2] = ((phase_r / 17'd100) % 17'd10) != 17'd0;
      corr_nxt[1] = ((phase_r / 17'd10) % 17'd10) != 17'd0;
      corr_nxt[0] = (phase_r % 17'd10) != 17'd0;
      if (frac_act_r == 14'h0000) corr_nxt = 5'h00;
   end
   // Comparison sequencer: up ramp, hold, sample, down ramp
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= frac_n_pkg::SEQ_IDLE;
         seq_cnt_r <= 4'h0;
         up_ramp_gate <= 1'b0;
         sample_strobe <= 1'b0;
         down_ramp_en <= 1'b0;
         phase_correction_bits <= 5'h00;
      end else begin
         sample_strobe <= 1'b0;
         unique case (state_r)
            frac_n_pkg::SEQ_IDLE, frac_n_pkg::SEQ_DOWN: begin
               if (state_r == frac_n_pkg::SEQ_DOWN && osc10_tick) begin
                  seq_cnt_r <= seq_cnt_r + 4'h1;
                  if (seq_cnt_r == frac_n_pkg::DOWN_PULSES - 4'h1) begin
                     down_ramp_en <= 1'b0;
                     phase_correction_bits <= 5'h00;
                     state_r <= frac_n_pkg::SEQ_IDLE;
                  end
               end
               if (frac_act_r == 14'h0000) phase_correction_bits <= 5'h00;
               // A divider pulse mid down ramp is ignored; the loop is not locked then
               if (state_r == frac_n_pkg::SEQ_IDLE && cycle_end) begin
                  up_ramp_gate <= 1'b1;
                  state_r <= frac_n_pkg::SEQ_UP;
               end
            end
            frac_n_pkg::SEQ_UP: begin
               if (ref_tick) begin
                  up_ramp_gate <= 1'b0;
                  seq_cnt_r <= 4'h0;
                  state_r <= frac_n_pkg::SEQ_HOLD;
               end
            end
            frac_n_pkg::SEQ_HOLD: begin
               seq_cnt_r <= seq_cnt_r + 4'h1;
               if (seq_cnt_r == 4'(frac_n_pkg::HOLD_CYC - 1)) begin
                  sample_strobe <= 1'b1;
                  state_r <= frac_n_pkg::SEQ_SAMPLE;
               end
            end
            frac_n_pkg::SEQ_SAMPLE: begin
               down_ramp_en <= 1'b1;
               phase_correction_bits <= corr_nxt;
               seq_cnt_r <= 4'h0;
               state_r <= frac_n_pkg::SEQ_DOWN;
            end
         endcase
      end
   end

   // AXI4-Lite write path: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= frac_n_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_held_r && w_held_r && !s_axi_bvalid) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            unique case (aw_addr_r & 4'hc)
               frac_n_pkg::OFS_INT_SET, frac_n_pkg::OFS_FRAC_SET: s_axi_bresp <= frac_n_pkg::RESP_OKAY;
               frac_n_pkg::OFS_STATUS, frac_n_pkg::OFS_COUNTERS: s_axi_bresp <= frac_n_pkg::RESP_SLVERR;
               default: s_axi_bresp <= frac_n_pkg::RESP_DECERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
   end

   // Setting registers; out-of-range values are dropped and the old setting kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_set_r <= frac_n_pkg::INT_SET_RST;
         frac_set_r <= frac_n_pkg::FRAC_SET_RST;
      end else if (aw_held_r && w_held_r && !s_axi_bvalid && (w_strb_r[1:0] == 2'h3)) begin
         if ((aw_addr_r & 4'hc) == frac_n_pkg::OFS_INT_SET && w_data_r[9:0] >= frac_n_pkg::N_MIN
             && w_data_r[9:0] <= frac_n_pkg::N_MAX) int_set_r <= w_data_r[9:0];
         if ((aw_addr_r & 4'hc) == frac_n_pkg::OFS_FRAC_SET && w_data_r[13:0] <= frac_n_pkg::FRAC_MAX)
            frac_set_r <= w_data_r[13:0];
      end
   end

   // Read data mux
   always_comb begin
      rd_word = 32'h0;
      rd_resp = frac_n_pkg::RESP_OKAY;
      unique case (s_axi_araddr & 4'hc)
         frac_n_pkg::OFS_INT_SET: rd_word[9:0] = int_set_r;
         frac_n_pkg::OFS_FRAC_SET: rd_word[13:0] = frac_set_r;
         frac_n_pkg::OFS_STATUS: begin
            rd_word[frac_n_pkg::ST_PHASE_LSB +: 17] = phase_r;
            rd_word[frac_n_pkg::ST_PEND_BIT] = swal_pend_r;
            rd_word[frac_n_pkg::ST_SWAL_BIT] = swal_act_r;
            rd_word[frac_n_pkg::ST_UDONE_BIT] = units_done_r;
            rd_word[frac_n_pkg::ST_GATE_BIT] = up_ramp_gate;
            rd_word[frac_n_pkg::ST_DOWN_BIT] = down_ramp_en;
         end
         frac_n_pkg::OFS_COUNTERS: begin
            rd_word[frac_n_pkg::CT_TENS_LSB +: 7] = tens_r;
            rd_word[frac_n_pkg::CT_UNITS_LSB +: 4] = units_r;
         end
         default: rd_resp = frac_n_pkg::RESP_DECERR;
      endcase
   end

   // AXI4-Lite read path: one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= frac_n_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_resp;
         end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      end
   end

   // Checks
   logic [7:0] down_osc10_r;
   always_ff @(posedge aclk) begin
      if (!aresetn || !down_ramp_en) down_osc10_r <= 8'h00;
      else if (osc10_tick) down_osc10_r <= down_osc10_r + 8'h01;
   end
   sequence s_ref_close;
      (state_r == frac_n_pkg::SEQ_UP) && ref_tick;
   endsequence
   sequence s_hold_then_sample;
      !up_ramp_gate && !down_ramp_en && !sample_strobe ##1 !down_ramp_en ##1 sample_strobe;
   endsequence
   a_gate_set_divider: assert property (@(posedge aclk) disable iff (!aresetn)
      (cycle_end && state_r == frac_n_pkg::SEQ_IDLE) |=> up_ramp_gate) else $error("gate not set by divider");
   a_gate_clear_ref: assert property (@(posedge aclk) disable iff (!aresetn)
      s_ref_close |=> !up_ramp_gate) else $error("gate not cleared by reference");
   a_ref_halved: assert property (@(posedge aclk) disable iff (!aresetn)
      ref_edge |=> ref_half_r != $past(ref_half_r)) else $error("reference not halved");
   a_cycle_order: assert property (@(posedge aclk) disable iff (!aresetn)
      s_ref_close |=> s_hold_then_sample ##1 down_ramp_en) else $error("comparison order broken");
   a_down_length: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(down_ramp_en) |-> $past(down_osc10_r) == 8'(frac_n_pkg::DOWN_PULSES - 4'h1))
      else $error("down ramp length wrong");
   a_corr_zero_frac: assert property (@(posedge aclk) disable iff (!aresetn)
      (frac_act_r == 14'h0000 && $stable(frac_act_r)) |-> phase_correction_bits == 5'h00)
      else $error("correction bits set with zero fraction");
   a_corr_only_down: assert property (@(posedge aclk) disable iff (!aresetn)
      !down_ramp_en |-> phase_correction_bits == 5'h00) else $error("correction outside down ramp");
   a_start_div11: assert property (@(posedge aclk) disable iff (!aresetn)
      (cycle_end && units_load != 4'h0) |=> modulus == frac_n_pkg::MOD_HI) else $error("cycle not starting at 11");
   a_units_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      units_terminal_pulse |-> units_done_r && units_r == 4'h0 && !swal_act_r) else $error("units terminal wrong");
   a_swallow_one: assert property (@(posedge aclk) disable iff (!aresetn)
      (swal_act_r && presc_out) |=> !swal_act_r) else $error("swallow longer than one period");
   a_pending_kept: assert property (@(posedge aclk) disable iff (!aresetn)
      (swal_req || (swal_pend_r && modulus == frac_n_pkg::MOD_HI)) |=> swal_pend_r) else $error("swallow lost");
   a_phase_bound: assert property (@(posedge aclk) disable iff (!aresetn)
      cycle_end |=> phase_r < frac_n_pkg::PHASE_WRAP) else $error("phase overflow not removed");
endmodule : fractional_n_divider_timing

//--- tb/osc_ref_model.sv
// Oscillator sample and 200 kHz reference source for the divider core
`timescale 1ns/100ps
module osc_ref_model (
   input wire logic aclk,
   input wire logic [2:0] half_cyc,
   output logic osc_sample_in,
   output logic ref_200k_in
);
   int osc_cnt = 0;
   int ref_cnt = 0;
   initial begin
      osc_sample_in = 1'b0;
      ref_200k_in = 1'b0;
   end
   // Each oscillator level lasts half_cyc clocks; the core needs two at least
   always @(posedge aclk) begin
      osc_cnt <= (osc_cnt + 1 >= int'(half_cyc)) ? 0 : osc_cnt + 1;
      if (osc_cnt + 1 >= int'(half_cyc)) osc_sample_in <= !osc_sample_in;
   end
   // Reference runs free: 50 clocks a level is 200 kHz at 20 MHz
   always @(posedge aclk) begin
      ref_cnt <= (ref_cnt == 49) ? 0 : ref_cnt + 1;
      if (ref_cnt == 49) ref_200k_in <= !ref_200k_in;
   end
endmodule : osc_ref_model

//--- tb/fractional_n_divider_timing_bench.sv
// Self-checking bench for the fractional-N divider timing core
`timescale 1ns/100ps
module fractional_n_divider_timing_bench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [2:0] half = 3'h4;
   logic awready, wready, bvalid, arready, rvalid, osc, refc;
   logic div_o, gate, strobe, down, swal, utp, osc_d, down_d, strobe_d, gate_d, swal_d;
   logic frac_on = 1'b0;
   logic seen_msd = 1'b0;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [4:0] pcb;
   int n_mismatch = 0;
   int samples_checked = 0;
   int ticks = 0, sum = 0, nper = 0, dticks = 0, glen = 0, ucnt = 0, cur_n = 0, swp = 0, swsum = 0, cur_exp = 0;
   logic [33:0] rd_q[$];
   logic [1:0] wr_q[$];
   int exp_q[$];
   int grp_q[$];

   always #25 aclk = ~aclk;

   fractional_n_divider_timing dut (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid),
      .s_axi_awready(awready),
      .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid),
      .s_axi_wready(wready),
      .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid),
      .s_axi_bready(bready),
      .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid),
      .s_axi_arready(arready),
      .s_axi_rdata(rdata),
      .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid),
      .s_axi_rready(rready),
      .osc_sample_in(osc),
      .ref_200k_in(refc),
      .divider_out(div_o),
      .up_ramp_gate(gate),
      .sample_strobe(strobe),
      .down_ramp_en(down),
      .swallow_active(swal),
      .units_terminal_pulse(utp),
      .phase_correction_bits(pcb)
   );

   osc_ref_model far_side (
      .aclk(aclk),
      .half_cyc(half),
      .osc_sample_in(osc),
      .ref_200k_in(refc)
   );

   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] expv);
      samples_checked++;
      if (seen !== expv) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish

   // A wait that runs out of cycles counts as a mismatch and ends the run
   task automatic hang(input string what);
      check(what, 34'h0, 34'h1);
      tally_and_finish();
   endtask : hang

   // Address and data offered together; each released on its own ready
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      wr_q.push_back(r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
         if (n > 100) hang("bvalid wait");
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      rd_q.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
         if (n > 100) hang("rvalid wait");
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask : axi_rd

   // Returns one edge after the k-th divider pulse, so the monitor has seen it
   task automatic wait_div(input int k);
      int n;
      repeat (k) begin
         n = 0;
         do begin
            @(posedge aclk);
            n++;
            if (n > 20000) hang("divider wait");
         end while (div_o !== 1'b1);
      end
      @(posedge aclk);
   endtask : wait_div

   // New setting lands at a reload, so two pulses pass before measuring
   task automatic run_n(input int n, input int per, input int expv);
      axi_wr(frac_n_pkg::OFS_INT_SET, 32'(n), frac_n_pkg::RESP_OKAY);
      wait_div(2);
      cur_n = n;
      grp_q.push_back(per);
      exp_q.push_back(expv);
      wait_div(per);
   endtask : run_n

   // Monitor retires the oldest note whenever a result shows at the ports
   always @(posedge aclk) begin
      if (bvalid === 1'b1 && bready === 1'b1) check("bresp", 34'(bresp), 34'(wr_q.pop_front()));
      if (rvalid === 1'b1 && rready === 1'b1) check("read", {rresp, rdata}, rd_q.pop_front());
      if (aresetn === 1'b1) begin
         if (osc === 1'b1 && osc_d === 1'b0) ticks++;
         if (osc === 1'b1 && osc_d === 1'b0 && down === 1'b1) dticks++;
         if (utp === 1'b1) ucnt++;
         if (swal === 1'b1 && swal_d === 1'b0) swp++;
         if (gate === 1'b1) glen++;
         if (pcb !== 5'h00 && (down !== 1'b1 || !frac_on)) check("idle bits", 34'(pcb), 34'h0);
         if (down === 1'b1 && frac_on && pcb !== 5'h00) check("bits", 34'(pcb), 34'h10);
         if (down === 1'b1 && pcb === 5'h10) seen_msd = 1'b1;
         if (strobe === 1'b1) check("gate at strobe", 34'(gate), 34'h0);
         if (down === 1'b1 && down_d === 1'b0) check("strobe first", 34'(strobe_d), 34'h1);
         if (down === 1'b0 && down_d === 1'b1) begin
            check("down ticks", 34'(dticks >= 119 && dticks <= 132), 34'h1);
            dticks = 0;
         end
         if (gate === 1'b0 && gate_d === 1'b1) begin
            check("gate length", 34'(glen <= 206), 34'h1);
            glen = 0;
         end
         if (div_o === 1'b1) begin
            check("gate at pulse", 34'(gate), 34'h1);
            if (grp_q.size() > 0) begin
               sum += ticks;
               swsum += swp;
               nper++;
               if (cur_n % 10 != 0) check("terminal pulses", 34'(ucnt), 34'h1);
               if (nper == grp_q[0]) begin
                  cur_exp = exp_q.pop_front();
                  check("osc ticks", 34'(sum), 34'(cur_exp));
                  check("swallows", 34'(swsum), 34'(cur_exp - nper * cur_n));
                  void'(grp_q.pop_front());
                  sum = 0;
                  swsum = 0;
                  nper = 0;
               end
            end
            ticks = 0;
            swp = 0;
            ucnt = 0;
         end
      end
      osc_d = osc;
      down_d = down;
      strobe_d = strobe;
      gate_d = gate;
      swal_d = swal;
   end

   initial begin
      int n;
      void'($urandom(32'h09cd4f2f));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check("outputs", 34'({down, gate, strobe, div_o, utp, swal, pcb}), 34'h0);
      axi_rd(frac_n_pkg::OFS_INT_SET, 32'h207, frac_n_pkg::RESP_OKAY);
      axi_rd(frac_n_pkg::OFS_FRAC_SET, 32'h0, frac_n_pkg::RESP_OKAY);
      axi_wr(frac_n_pkg::OFS_STATUS, 32'h0, frac_n_pkg::RESP_SLVERR);
      axi_wr(frac_n_pkg::OFS_INT_SET, 32'h1a3, frac_n_pkg::RESP_OKAY);
      axi_wr(frac_n_pkg::OFS_INT_SET, 32'h2c1, frac_n_pkg::RESP_OKAY);
      axi_rd(frac_n_pkg::OFS_INT_SET, 32'h207, frac_n_pkg::RESP_OKAY);
      run_n(519, 1, 519);
      n = $urandom_range(704, 420);
      half <= 3'h4 + 3'($urandom_range(1, 0));
      run_n(n, 1, n);
      run_n(704, 1, 704);
      axi_wr(frac_n_pkg::OFS_FRAC_SET, 32'h1388, frac_n_pkg::RESP_OKAY);
      frac_on = 1'b1;
      run_n(425, 4, 1702);
      check("msd seen", 34'(seen_msd), 34'h1);
      tally_and_finish();
   end
endmodule : fractional_n_divider_timing_bench
